//--- ercm_defines.vh
`ifndef ERCM_DEFINES_VH
`define ERCM_DEFINES_VH
// ==========================================================
// register indices (byte address = index)
`define ERCM_A_CTRL        8'h00
`define ERCM_A_OVR         8'h01
`define ERCM_A_BOARD_BOOST 8'h02
`define ERCM_A_STATUS      8'h03
`define ERCM_A_RATE        8'h04
`define ERCM_A_PRESET_LO   8'h40
`define ERCM_A_PRESET_HI   8'h4F
// ==========================================================
// ctrl bits
`define ERCM_C_SPLITTER    0
`define ERCM_C_BYPASS_EQ   1
`define ERCM_C_MANUAL      2
`define ERCM_C_CDR_RESET   3
`define ERCM_C_FIXED_SET   4
// override register bits
`define ERCM_O_ROUTE_EN    0
`define ERCM_O_RATE_EN     1
`define ERCM_O_ROUTE_LSB   2
`define ERCM_O_RATE_BIT    4
// ==========================================================
// four-level codes
`define ERCM_LVL_L         2'h0
`define ERCM_LVL_R         2'h1
`define ERCM_LVL_F         2'h2
`define ERCM_LVL_H         2'h3
// comparator thresholds, tenths of io_supply
`define ERCM_TH_LR         4'h2
`define ERCM_TH_RF         4'h5
`define ERCM_TH_FH         4'h8
// ==========================================================
// lock rate codes
`define ERCM_RT_11G88      4'h0
`define ERCM_RT_5G94       4'h1
`define ERCM_RT_2G97       4'h2
`define ERCM_RT_1G485      4'h3
`define ERCM_RT_270M       4'h4
`define ERCM_RT_11G88_D    4'h5
`define ERCM_RT_5G94_D     4'h6
`define ERCM_RT_2G97_D     4'h7
`define ERCM_RT_1G485_D    4'h8
`define ERCM_RT_10G3125    4'h9
// ==========================================================
// timing
`define ERCM_SETTLE_NS     1000
`define ERCM_CLK_NS        50
// settle count: ERCM_SETTLE_NS over ERCM_CLK_NS, sized for the 8-bit counter
`define ERCM_SETTLE_CYC    8'h14
`define ERCM_DWELL_CYC     8'h10
`define ERCM_MIN_BOOST     8'h00
`endif

//--- ercm_level_filter.v
`timescale 1ns/100ps
`default_nettype none
`include "ercm_defines.vh"
// ==========================================================
// four-level pin decode, sync and settle filter
module ercm_level_filter (
    input  wire       clk,
    input  wire       srst,
    input  wire [2:0] cmp_in,
    output reg  [1:0] level_r
);
    reg  [2:0] s1_r;
    reg  [2:0] s2_r;
    reg  [1:0] cand_r;
    reg  [7:0] cnt_r;
    reg  [1:0] dec;
    always @* begin
        // comparators at 0.2, 0.5, 0.8 of io_supply
        if (s2_r[2])
            dec = `ERCM_LVL_H;
        else if (s2_r[1])
            dec = `ERCM_LVL_F;
        else if (s2_r[0])
            dec = `ERCM_LVL_R;
        else
            dec = `ERCM_LVL_L;
    end
    always @(posedge clk) begin
        if (srst) begin
            // open pin code, so no false candidate after reset
            s1_r    <= 3'h3;
            s2_r    <= 3'h3;
            cand_r  <= `ERCM_LVL_F;
            cnt_r   <= 8'h00;
            level_r <= `ERCM_LVL_F;
        end else begin
            s1_r <= cmp_in;
            s2_r <= s1_r;
            if (dec != cand_r) begin
                cand_r <= dec;
                cnt_r  <= 8'h00;
            end else if (cnt_r == `ERCM_SETTLE_CYC) begin
                level_r <= cand_r;
            end else begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end
endmodule // ercm_level_filter
`default_nettype wire

//--- ercm_mode_ctrl.v
`timescale 1ns/100ps
`default_nettype none
`include "ercm_defines.vh"
module ercm_mode_ctrl (
    input  wire       CLK_SYS,
    input  wire       SRST,
    input  wire [2:0] ROUTE_CMP,
    input  wire [2:0] OUTFN_CMP,
    input  wire       CD_CABLE,
    input  wire       CD_BOARD,
    input  wire [7:0] EYE_SCORE,
    input  wire       CDR_LOCKED,
    input  wire [7:0] ADDR,
    input  wire [7:0] WDATA,
    input  wire       WR,
    input  wire       RD,
    output reg  [7:0] RDATA,
    output reg        NORMAL_MODE,
    output reg        CABLE_EQ_ON,
    output reg        BOARD_EQ_ON,
    output reg        EQ_BYPASS,
    output reg        SPLITTER_MODE,
    output reg        CABLE_ADAPT,
    output reg  [7:0] BOARD_BOOST,
    output reg        FIRST_OUTPUT_EN,
    output reg        SECOND_OUTPUT_EN,
    output reg        VIDEO_FAMILY,
    output reg  [3:0] LOCK_RATE,
    output reg        CDR_RESET,
    output reg        RECLOCK_EN
);
    // ======================================================
    // pin decode
    wire [1:0] route_lvl;
    wire [1:0] outfn_lvl;
    ercm_level_filter u_route (
        .clk     (CLK_SYS),
        .srst    (SRST),
        .cmp_in  (ROUTE_CMP),
        .level_r (route_lvl)
    );
    ercm_level_filter u_outfn (
        .clk     (CLK_SYS),
        .srst    (SRST),
        .cmp_in  (OUTFN_CMP),
        .level_r (outfn_lvl)
    );
    // ======================================================
    // registers
    reg  [7:0] ctrl_r;
    reg  [7:0] ovr_r;
    reg  [7:0] fixed_r;
    reg  [3:0] rate_r;
    reg  [7:0] preset_r [0:15];
    reg        cd1_r;
    reg        cd2_r;
    reg        cb1_r;
    reg        cb2_r;
    reg        lk1_r;
    reg        lk2_r;
    reg        best_valid_r;
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            ctrl_r  <= 8'h00;
            ovr_r   <= 8'h00;
            fixed_r <= `ERCM_MIN_BOOST;
            rate_r  <= `ERCM_RT_11G88;
        end else if (WR) begin
            case (ADDR)
                `ERCM_A_CTRL: begin
                    ctrl_r <= WDATA;
                end
                `ERCM_A_OVR: begin
                    ovr_r <= WDATA;
                end
                `ERCM_A_BOARD_BOOST: begin
                    fixed_r <= WDATA;
                end
                `ERCM_A_RATE: begin
                    rate_r <= WDATA[3:0];
                end
                default: begin
                end
            endcase
        end
    end
    // ======================================================
    // preset table, one entry per step
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_preset
            localparam integer P_IDX  = g;
            localparam [7:0]   P_INIT = {P_IDX[3:0], 4'h0};
            localparam [7:0]   P_ADDR = `ERCM_A_PRESET_LO | {4'h0, P_IDX[3:0]};
            always @(posedge CLK_SYS) begin
                if (SRST) begin
                    preset_r[g] <= P_INIT;
                end else if (WR && (ADDR == P_ADDR)) begin
                    preset_r[g] <= WDATA;
                end
            end
        end
    endgenerate
    // ======================================================
    // synchronisers for link-side status
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            cd1_r <= 1'b0;
            cd2_r <= 1'b0;
            cb1_r <= 1'b0;
            cb2_r <= 1'b0;
            lk1_r <= 1'b0;
            lk2_r <= 1'b0;
        end else begin
            cd1_r <= CD_CABLE;
            cd2_r <= cd1_r;
            cb1_r <= CD_BOARD;
            cb2_r <= cb1_r;
            lk1_r <= CDR_LOCKED;
            lk2_r <= lk1_r;
        end
    end
    // ======================================================
    // routing and family
    reg  [1:0] route_eff;
    reg        sel_board;
    reg        fam_video;
    reg        second_output_en;
    reg        out2_en;
    reg        rate_video;
    reg        carrier;
    reg        bypass_now;
    always @* begin
        route_eff = ovr_r[`ERCM_O_ROUTE_EN] ? ovr_r[`ERCM_O_ROUTE_LSB +: 2] : route_lvl;
        sel_board = (route_eff == `ERCM_LVL_R) || (route_eff == `ERCM_LVL_L);
        second_output_en   = (route_eff != `ERCM_LVL_R);
        out2_en   = (route_eff != `ERCM_LVL_F);
        fam_video = ovr_r[`ERCM_O_RATE_EN] ? ovr_r[`ERCM_O_RATE_BIT] : !sel_board;
        carrier   = sel_board ? cb2_r : cd2_r;
        rate_video = (rate_r <= `ERCM_RT_1G485_D);
        // same-cycle bypass, so equalizer power never lags the bypass flag
        bypass_now = ctrl_r[`ERCM_C_BYPASS_EQ] || (outfn_lvl == `ERCM_LVL_H);
    end
    // ======================================================
    // board preset search
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_DWELL = 2'h1;
    localparam [1:0] ST_NEXT  = 2'h2;
    localparam [1:0] ST_DONE  = 2'h3;
    reg  [1:0] st_r;
    reg  [1:0] st_nxt;
    reg  [3:0] idx_r;
    reg  [3:0] best_r;
    reg  [7:0] best_score_r;
    reg  [7:0] dwell_r;
    reg  [7:0] boost_nxt;
    reg        adapt_ok;
    reg        board_auto;
    always @* begin
        adapt_ok = fam_video ?
            (rate_r == `ERCM_RT_11G88) || (rate_r == `ERCM_RT_5G94) || (rate_r == `ERCM_RT_2G97) ||
            (rate_r == `ERCM_RT_11G88_D) || (rate_r == `ERCM_RT_5G94_D) || (rate_r == `ERCM_RT_2G97_D)
            : 1'b1;
        board_auto = !ctrl_r[`ERCM_C_MANUAL] && adapt_ok;
        st_nxt = st_r;
        case (st_r)
            ST_IDLE: begin
                if (board_auto && sel_board && carrier)
                    st_nxt = ST_DWELL;
            end
            ST_DWELL: begin
                if (dwell_r == `ERCM_DWELL_CYC)
                    st_nxt = ST_NEXT;
            end
            ST_NEXT: begin
                st_nxt = (idx_r == 4'hF) ? ST_DONE : ST_DWELL;
            end
            ST_DONE: begin
                st_nxt = ST_DONE;
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
        if (!(board_auto && sel_board && carrier))
            st_nxt = ST_IDLE;
    end
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            st_r         <= ST_IDLE;
            idx_r        <= 4'h0;
            best_r       <= 4'h0;
            best_score_r <= 8'h00;
            dwell_r      <= 8'h00;
            best_valid_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            if (st_nxt == ST_IDLE) begin
                idx_r        <= 4'h0;
                best_score_r <= 8'h00;
                dwell_r      <= 8'h00;
                best_valid_r <= 1'b0;
            end else if (st_r == ST_DWELL) begin
                dwell_r <= dwell_r + 8'h01;
                if (st_nxt == ST_NEXT && (!best_valid_r || EYE_SCORE > best_score_r)) begin
                    best_r       <= idx_r;
                    best_score_r <= EYE_SCORE;
                    best_valid_r <= 1'b1;
                end
            end else if (st_r == ST_NEXT) begin
                dwell_r <= 8'h00;
                if (idx_r != 4'hF)
                    idx_r <= idx_r + 4'h1;
            end
        end
    end
    always @* begin
        if (!board_auto)
            boost_nxt = fixed_r;
        else if (st_r == ST_DONE)
            boost_nxt = preset_r[best_r];
        else
            boost_nxt = preset_r[idx_r];
    end
    // ======================================================
    // outputs
    reg        fam_prev_r;
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            NORMAL_MODE      <= 1'b0;
            CABLE_EQ_ON      <= 1'b0;
            BOARD_EQ_ON      <= 1'b0;
            EQ_BYPASS        <= 1'b0;
            SPLITTER_MODE    <= 1'b0;
            CABLE_ADAPT      <= 1'b0;
            BOARD_BOOST      <= `ERCM_MIN_BOOST;
            FIRST_OUTPUT_EN  <= 1'b0;
            SECOND_OUTPUT_EN <= 1'b0;
            VIDEO_FAMILY     <= 1'b1;
            LOCK_RATE        <= `ERCM_RT_11G88;
            CDR_RESET        <= 1'b1;
            RECLOCK_EN       <= 1'b0;
            fam_prev_r       <= 1'b1;
        end else begin
            NORMAL_MODE      <= carrier;
            EQ_BYPASS        <= bypass_now;
            CABLE_EQ_ON      <= carrier && !sel_board && !bypass_now;
            BOARD_EQ_ON      <= carrier && sel_board && !bypass_now;
            SPLITTER_MODE    <= ctrl_r[`ERCM_C_SPLITTER];
            CABLE_ADAPT      <= carrier && !sel_board && !bypass_now;
            BOARD_BOOST      <= boost_nxt;
            FIRST_OUTPUT_EN  <= carrier && second_output_en;
            SECOND_OUTPUT_EN <= carrier && out2_en;
            VIDEO_FAMILY     <= fam_video;
            fam_prev_r       <= fam_video;
            // lock rate from family, 270M has no divided variant
            if (!fam_video)
                LOCK_RATE <= `ERCM_RT_10G3125;
            else if (rate_video)
                LOCK_RATE <= rate_r;
            else
                LOCK_RATE <= `ERCM_RT_11G88;
            // carrier loss resets recovery; host resets on family change
            CDR_RESET  <= ctrl_r[`ERCM_C_CDR_RESET] || !carrier;
            RECLOCK_EN <= carrier && lk2_r && (outfn_lvl != `ERCM_LVL_H)
                          && (outfn_lvl != `ERCM_LVL_L);
        end
    end
    // ======================================================
    // read port
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            case (ADDR)
                `ERCM_A_CTRL:        RDATA <= ctrl_r;
                `ERCM_A_OVR:         RDATA <= ovr_r;
                `ERCM_A_BOARD_BOOST: RDATA <= BOARD_BOOST;
                `ERCM_A_STATUS:      RDATA <= {lk2_r, fam_prev_r, sel_board, st_r, route_lvl, NORMAL_MODE};
                `ERCM_A_RATE:        RDATA <= {4'h0, LOCK_RATE};
                default: begin
                    if (ADDR >= `ERCM_A_PRESET_LO && ADDR <= `ERCM_A_PRESET_HI)
                        RDATA <= preset_r[ADDR[3:0]];
                    else
                        RDATA <= 8'h00;
                end
            endcase
        end else begin
            RDATA <= 8'h00;
        end
    end
endmodule // ercm_mode_ctrl
`default_nettype wire

//--- ercm_far_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// far-side source: carrier per input, eye peaks at one preset
module ercm_far_model (
    input  wire logic       cable_on,
    input  wire logic       board_on,
    input  wire logic [7:0] boost,
    input  wire logic [3:0] best,
    output wire logic       cd_cable,
    output wire logic       cd_board,
    output wire logic [7:0] eye_score
);
    wire logic [7:0] tgt;
    wire logic [7:0] diff;
    assign tgt       = {best, 4'h0};
    assign diff      = (boost > tgt) ? boost - tgt : tgt - boost;
    assign cd_cable  = cable_on;
    assign cd_board  = board_on;
    // unique peak so the search has one right answer
    assign eye_score = 8'hFF - diff;
endmodule // ercm_far_model
`default_nettype wire

//--- ercm_mode_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// port checker for mode control
module ercm_mode_sva (
    input wire logic       CLK_SYS,
    input wire logic       SRST,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic [7:0] RDATA,
    input wire logic       NORMAL_MODE,
    input wire logic       CABLE_EQ_ON,
    input wire logic       BOARD_EQ_ON,
    input wire logic       EQ_BYPASS,
    input wire logic       SPLITTER_MODE,
    input wire logic       FIRST_OUTPUT_EN,
    input wire logic       SECOND_OUTPUT_EN,
    input wire logic       VIDEO_FAMILY,
    input wire logic       CDR_RESET,
    input wire logic [3:0] LOCK_RATE
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);
    property p_rdata_idle; !$past(RD) |-> RDATA == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
    property p_one_eq; !(CABLE_EQ_ON && BOARD_EQ_ON); endproperty
    a_one_eq: assert property (p_one_eq) else $error("both equalizers powered");
    property p_split;
        // ctrl register one edge, output flop the next
        WR && ADDR == 8'h00 |-> ##2 SPLITTER_MODE == $past(WDATA[0], 2);
    endproperty
    a_split: assert property (p_split) else $error("splitter not following ctrl");
    property p_bypass; EQ_BYPASS [*3] |-> !CABLE_EQ_ON && !BOARD_EQ_ON; endproperty
    a_bypass: assert property (p_bypass) else $error("equalizer on in bypass");
    property p_idle_out;
        !NORMAL_MODE [*3] |-> !FIRST_OUTPUT_EN && !SECOND_OUTPUT_EN && !CABLE_EQ_ON && !BOARD_EQ_ON;
    endproperty
    a_idle_out: assert property (p_idle_out) else $error("active in power save");
    property p_cdr_idle; !NORMAL_MODE [*3] |-> CDR_RESET; endproperty
    a_cdr_idle: assert property (p_cdr_idle) else $error("recovery not held without carrier");
    property p_rate_set; LOCK_RATE <= 4'h9; endproperty
    a_rate_set: assert property (p_rate_set) else $error("lock rate code out of set");
    property p_tengig; !VIDEO_FAMILY [*3] |-> LOCK_RATE == 4'h9; endproperty
    a_tengig: assert property (p_tengig) else $error("10GbE family not at 10.3125");
    property p_first_only;
        (FIRST_OUTPUT_EN && !SECOND_OUTPUT_EN) [*3] |-> CABLE_EQ_ON || EQ_BYPASS;
    endproperty
    a_first_only: assert property (p_first_only) else $error("first output only without cable");
    c_board: cover property (BOARD_EQ_ON && SECOND_OUTPUT_EN);
    c_cable: cover property (CABLE_EQ_ON && !SECOND_OUTPUT_EN);
    c_split: cover property ($rose(SPLITTER_MODE));
endmodule // ercm_mode_sva
`default_nettype wire

//--- ercm_mode_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ercm_defines.vh"
module ercm_mode_ctrl_tb_top;
    logic       clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, locked = 1'b1;
    logic       cable_on = 1'b1, board_on = 1'b1;
    logic [2:0] route_cmp = 3'h3, outfn_cmp = 3'h3;
    logic [7:0] addr = 8'h00, wdata = 8'h00, fb;
    logic [3:0] best = 4'h0;
    logic [1:0] lvl;
    wire  [7:0] rdata, boost, eye;
    wire  [3:0] rate;
    wire        cd_c, cd_b, normal, c_eq, b_eq, byp, split, fam, cdr_rst, reclk, second_output, out2, c_adapt;
    integer     miscompares = 0;
    integer     comparisons = 0;
    always #25 clk = ~clk;
    ercm_far_model ercm_far_model_i (.cable_on(cable_on), .board_on(board_on), .boost(boost), .best(best),
        .cd_cable(cd_c), .cd_board(cd_b), .eye_score(eye));
    ercm_mode_ctrl ercm_mode_ctrl_i (.CLK_SYS(clk), .SRST(srst), .ROUTE_CMP(route_cmp), .OUTFN_CMP(outfn_cmp),
        .CD_CABLE(cd_c), .CD_BOARD(cd_b), .EYE_SCORE(eye), .CDR_LOCKED(locked), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .NORMAL_MODE(normal), .CABLE_EQ_ON(c_eq), .BOARD_EQ_ON(b_eq),
        .EQ_BYPASS(byp), .SPLITTER_MODE(split), .CABLE_ADAPT(c_adapt), .BOARD_BOOST(boost), .FIRST_OUTPUT_EN(second_output),
        .SECOND_OUTPUT_EN(out2), .VIDEO_FAMILY(fam), .LOCK_RATE(rate), .CDR_RESET(cdr_rst), .RECLOCK_EN(reclk));
    // ==========================================
    // expectations
    function automatic [2:0] lvl2cmp(input [1:0] l);
        lvl2cmp = {l == `ERCM_LVL_H, l >= `ERCM_LVL_F, l >= `ERCM_LVL_R};
    endfunction
    // {cable eq, board eq, first, second, video}
    function automatic [4:0] route_exp(input [1:0] l);
        route_exp = {l[1], !l[1], l != `ERCM_LVL_R, l != `ERCM_LVL_F, l[1]};
    endfunction
    // ==========================================
    // helpers
    task automatic give_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input [7:0] exp, input [7:0] got);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wreg(input [7:0] a, input [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input [7:0] a, input [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk("rdata", exp, rdata);
    endtask
    // ==========================================
    // watchdog
    initial begin
        #(50 * 20000);
        miscompares = miscompares + 1;
        give_verdict();
    end
    initial begin
        void'($urandom(74));
        best = 4'($urandom % 16);
        fb = 8'($urandom);
        repeat (6) @(negedge clk);
        chk("reset", 8'h06, {5'h0, fam, cdr_rst, normal});
        chk("reset boost", 8'h00, boost | {4'h0, rate});
        @(posedge clk) srst <= 1'b0;
        // pin starts open, i.e. level F
        for (int i = 3; i >= 0; i--) begin
            lvl = 2'(i);
            @(posedge clk) route_cmp <= lvl2cmp(lvl);
            idle(40);
            chk("route", {3'h0, route_exp(lvl)}, {3'h0, c_eq, b_eq, second_output, out2, fam});
            chk("reclock", 8'h01, {7'h0, reclk});
            chk("cable adapt", {7'h0, lvl[1]}, {7'h0, c_adapt});
            chk("lock rate", lvl[1] ? {4'h0, `ERCM_RT_11G88} : {4'h0, `ERCM_RT_10G3125}, {4'h0, rate});
        end
        idle(320);
        chk("search", {best, 4'h0}, boost);
        wreg(`ERCM_A_CTRL, 8'h04);
        wreg(`ERCM_A_BOARD_BOOST, fb);
        idle(4);
        chk("manual", fb, boost);
        wreg(`ERCM_A_CTRL, 8'h00);
        wreg(`ERCM_A_OVR, 8'h12);
        for (int c = 0; c < 10; c++) begin
            wreg(`ERCM_A_RATE, 8'(c));
            idle(3);
            chk("rate", (c > 8) ? 8'h00 : 8'(c), {4'h0, rate});
        end
        wreg(`ERCM_A_RATE, 8'h03);
        wreg(`ERCM_A_CTRL, 8'h08);
        wreg(`ERCM_A_CTRL, 8'h00);
        idle(4);
        chk("fixed", fb, boost);
        chk("video", 8'h01, {7'h0, fam});
        rreg(`ERCM_A_RATE, 8'h03);
        wreg(`ERCM_A_OVR, 8'h1F);
        idle(4);
        chk("override", {3'h0, route_exp(`ERCM_LVL_H)}, {3'h0, c_eq, b_eq, second_output, out2, fam});
        wreg(`ERCM_A_OVR, 8'h00);
        wreg(`ERCM_A_CTRL, 8'h08);
        wreg(`ERCM_A_CTRL, 8'h02);
        idle(4);
        chk("bypass reg", 8'h04, {5'h0, byp, c_eq, b_eq});
        wreg(`ERCM_A_CTRL, 8'h00);
        @(posedge clk) outfn_cmp <= lvl2cmp(`ERCM_LVL_H);
        idle(40);
        chk("bypass pin", 8'h04, {5'h0, byp, c_eq, b_eq});
        @(posedge clk) outfn_cmp <= lvl2cmp(`ERCM_LVL_F);
        idle(40);
        wreg(`ERCM_A_CTRL, 8'h01);
        idle(4);
        chk("splitter", 8'h01, {7'h0, split});
        rreg(`ERCM_A_CTRL, 8'h01);
        wreg(`ERCM_A_CTRL, 8'h00);
        rreg(8'h20, 8'h00);
        rreg(8'h45, 8'h50);
        @(posedge clk) cable_on <= 1'b0;
        idle(10);
        chk("other carrier", 8'h01, {7'h0, normal});
        @(posedge clk) board_on <= 1'b0;
        idle(10);
        chk("save", 8'h01, {5'h0, normal, b_eq, cdr_rst});
        @(posedge clk) board_on <= 1'b1;
        idle(10);
        chk("wake", 8'h01, {7'h0, normal});
        @(posedge clk) locked <= 1'b0;
        idle(6);
        chk("unlocked", 8'h00, {7'h0, reclk});
        give_verdict();
    end
endmodule // ercm_mode_ctrl_tb_top
bind ercm_mode_ctrl ercm_mode_sva ercm_mode_sva_i (.CLK_SYS, .SRST, .WR, .RD, .ADDR, .WDATA, .RDATA,
    .NORMAL_MODE, .CABLE_EQ_ON, .BOARD_EQ_ON, .EQ_BYPASS, .SPLITTER_MODE, .FIRST_OUTPUT_EN,
    .SECOND_OUTPUT_EN, .VIDEO_FAMILY, .CDR_RESET, .LOCK_RATE);
`default_nettype wire
